// ---- pkg/ctp_pkg.sv ----
// Constants for the dual counter/timer block: offsets, fields, resets.
// Assumes a 32-bit APB slave with byte addresses on paddr.
package ctp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_MODE  = 8'h04;
  localparam logic [7:0] OFF_CLK   = 8'h08;
  localparam logic [7:0] OFF_EXTC  = 8'h0C;
  localparam logic [7:0] OFF_T0LO  = 8'h10;
  localparam logic [7:0] OFF_T0HI  = 8'h14;
  localparam logic [7:0] OFF_T1LO  = 8'h18;
  localparam logic [7:0] OFF_T1HI  = 8'h1C;
  localparam logic [7:0] OFF_STAT  = 8'h20;
  localparam logic [7:0] OFF_CLR   = 8'h24;
  localparam logic [7:0] OFF_IEN   = 8'h28;
  // Control register fields
  localparam int RUN0_BIT = 4;
  localparam int OVF0_BIT = 5;
  localparam int RUN1_BIT = 6;
  localparam int OVF1_BIT = 7;
  // Mode register fields, second timer sits at +MODE_T1_SHIFT
  localparam int MODE_LSB      = 0;
  localparam int CSEL_BIT      = 2;
  localparam int GATE_BIT      = 3;
  localparam int MODE_T1_SHIFT = 4;
  // Clock control fields
  localparam int SCALE_LSB = 0;
  localparam int SYS0_BIT  = 3;
  localparam int SYS1_BIT  = 4;
  // External interrupt config: gate polarity bits
  localparam int POL0_BIT = 3;
  localparam int POL1_BIT = 7;
  // Mode encodings and count layout
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam int LO_BITS = 5;
  // Prescaler divide counts, indexed by the scale field
  localparam logic [5:0] DIV_SC0 = 6'h0C;
  localparam logic [5:0] DIV_SC1 = 6'h04;
  localparam logic [5:0] DIV_SC2 = 6'h30;
  localparam logic [5:0] DIV_SC3 = 6'h08;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_FLAG = 2'h0;
  localparam logic [5:0] RST_PRE  = 6'h00;
endpackage

// ---- design/ctp_top.sv ----
// Dual 13-bit counter/timer with APB register access and one interrupt.
// Assumes count and gate pins are synchronous-sampled on pclk only.
`timescale 1ns/100ps

// One timer channel: count source choice, run gating, 13-bit count
module ctp_timer
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Configuration
  input  wire logic       run_bit,
  input  wire logic       gate_bit,
  input  wire logic       gate_active,
  input  wire logic       counter_select_bit,
  input  wire logic       sysclk_select_bit,
  input  wire logic [1:0] mode_select_bits,
  // Count sources
  input  wire logic       scale_tick,
  input  wire logic       pin_fall,
  // Byte writes
  input  wire logic       wr_lo,
  input  wire logic       wr_hi,
  input  wire logic [7:0] wdata,
  // Count state
  output logic      [7:0] low_byte,
  output logic      [7:0] high_byte,
  output logic            overflow
);
  logic       src_tick;
  logic       enabled;
  logic       step;
  logic [12:0] cnt13;
  logic [12:0] nxt13;
  logic [7:0] lo_q;
  logic [7:0] hi_q;

  always_comb
  begin
    if (counter_select_bit)
      src_tick = pin_fall;
    else if (sysclk_select_bit)
      src_tick = 1'b1;
    else
      src_tick = scale_tick;
  end

  assign enabled = run_bit & (~gate_bit | gate_active);
  assign step = enabled & src_tick & (mode_select_bits == ctp_pkg::MODE_13BIT);

  assign cnt13 = {hi_q, lo_q[ctp_pkg::LO_BITS-1:0]};
  assign nxt13 = cnt13 + 13'h0001;

  // Low byte: software write wins over a count step
  // count kept when run set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lo_q <= ctp_pkg::RST_BYTE;
    else if (wr_lo)
      lo_q <= wdata;
    else if (step)
      lo_q[ctp_pkg::LO_BITS-1:0] <= nxt13[ctp_pkg::LO_BITS-1:0];
  end

  // High byte takes the carry out of the five low bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_q <= ctp_pkg::RST_BYTE;
    else if (wr_hi)
      hi_q <= wdata;
    else if (step)
      hi_q <= nxt13[12:ctp_pkg::LO_BITS];
  end

  assign overflow  = step & (&cnt13) & ~wr_lo & ~wr_hi;
  assign low_byte  = lo_q;
  assign high_byte = hi_q;
endmodule

// Contract
// - Each timer holds a 13-bit count reached as low and high bytes.
// - Each timer has its own mode bits; the two configure independently.
// - Mode zero counts 13 bits: high byte eight MSBs, low bits 4..0.
// - Wrap from all ones sets overflow flag and interrupt if enabled.
// - Counter select set: each falling count pin edge increments.
// - Counter select clear: system clock if selected, else prescaled clock.
// - Count only when run set and gate clear or gate input active.
// - Gate input active level set by its polarity bit.
// - Setting run does not clear count; software preloads bytes.
// - Second timer identical with own bytes, bits, gate input, polarity.
module ctp_top
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External pins
  input  wire logic        first_count_pin,
  input  wire logic        second_count_pin,
  input  wire logic        first_ext_gate_input,
  input  wire logic        second_ext_gate_input,
  // Interrupt
  output logic             irq
);
  logic [7:0]  timer_control_register_q;
  logic [7:0]  timer_mode_register_q;
  logic [7:0]  clock_control_register_q;
  logic [7:0]  ext_interrupt_config_register_q;
  logic [1:0]  ovf_flag_q;
  logic [1:0]  irq_enable_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic [5:0]  pre_cnt_q;
  logic [5:0]  pre_div;
  logic        scale_tick;
  logic [2:0]  cnt0_sync_q;
  logic [2:0]  cnt1_sync_q;
  logic [1:0]  first_gate_bit_sync_q;
  logic [1:0]  gate1_sync_q;
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_d;
  logic [1:0]  ovf_evt;
  logic [1:0]  fall;
  logic [1:0]  gate_act;
  logic [1:0]  wr_lo;
  logic [1:0]  wr_hi;
  logic [7:0]  lo_b [2];
  logic [7:0]  hi_b [2];

  // APB access: answer one cycle into the access phase
  assign access = psel & penable & ~pready_q;
  assign wr_en  = psel & penable & pready_q & pwrite & ~pslverr_q;

  // Ready pulse, one per transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_q <= 1'b0;
    else
      pready_q <= access;
  end

  // Address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    rd_d   = 32'h0000_0000;
    unique case (paddr)
      ctp_pkg::OFF_CTRL: rd_d[7:0] = timer_control_register_q;
      ctp_pkg::OFF_MODE: rd_d[7:0] = timer_mode_register_q;
      ctp_pkg::OFF_CLK:  rd_d[7:0] = clock_control_register_q;
      ctp_pkg::OFF_EXTC: rd_d[7:0] = ext_interrupt_config_register_q;
      ctp_pkg::OFF_T0LO: rd_d[7:0] = lo_b[0];
      ctp_pkg::OFF_T0HI: rd_d[7:0] = hi_b[0];
      ctp_pkg::OFF_T1LO: rd_d[7:0] = lo_b[1];
      ctp_pkg::OFF_T1HI: rd_d[7:0] = hi_b[1];
      ctp_pkg::OFF_STAT: rd_d[1:0] = ovf_flag_q;
      ctp_pkg::OFF_CLR:  rd_d      = 32'h0000_0000;
      ctp_pkg::OFF_IEN:  rd_d[1:0] = irq_enable_q;
      default:           mapped    = 1'b0;
    endcase
  end

  // Read data and error captured with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (access)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr_q <= ~mapped;
    end
    else
    begin
      pslverr_q <= 1'b0;
    end
  end

  // Configuration registers; overflow bits in control read from flags
  // independent mode fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_register_q        <= ctp_pkg::RST_BYTE;
      timer_mode_register_q           <= ctp_pkg::RST_BYTE;
      clock_control_register_q        <= ctp_pkg::RST_BYTE;
      ext_interrupt_config_register_q <= ctp_pkg::RST_BYTE;
      irq_enable_q                    <= ctp_pkg::RST_FLAG;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ctp_pkg::OFF_CTRL:
        begin
          timer_control_register_q[ctp_pkg::RUN0_BIT] <= pwdata[ctp_pkg::RUN0_BIT];
          timer_control_register_q[ctp_pkg::RUN1_BIT] <= pwdata[ctp_pkg::RUN1_BIT];
        end
        ctp_pkg::OFF_MODE: timer_mode_register_q           <= pwdata[7:0];
        ctp_pkg::OFF_CLK:  clock_control_register_q        <= pwdata[7:0];
        ctp_pkg::OFF_EXTC: ext_interrupt_config_register_q <= pwdata[7:0];
        ctp_pkg::OFF_IEN:  irq_enable_q                    <= pwdata[1:0];
        default:           irq_enable_q                    <= irq_enable_q;
      endcase
    end
    else
    begin
      timer_control_register_q[ctp_pkg::OVF0_BIT] <= ovf_flag_q[0];
      timer_control_register_q[ctp_pkg::OVF1_BIT] <= ovf_flag_q[1];
    end
  end

  // Byte write strobes per timer
  assign wr_lo[0] = wr_en & (paddr == ctp_pkg::OFF_T0LO);
  assign wr_hi[0] = wr_en & (paddr == ctp_pkg::OFF_T0HI);
  assign wr_lo[1] = wr_en & (paddr == ctp_pkg::OFF_T1LO);
  assign wr_hi[1] = wr_en & (paddr == ctp_pkg::OFF_T1HI);

  // Sticky overflow flags: a set in the clear cycle wins
  // overflow flag set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_flag_q <= ctp_pkg::RST_FLAG;
    else if (wr_en && paddr == ctp_pkg::OFF_CLR)
      ovf_flag_q <= (ovf_flag_q & ~pwdata[1:0]) | ovf_evt;
    else
      ovf_flag_q <= ovf_flag_q | ovf_evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(ovf_flag_q & irq_enable_q);
  end

  // Prescaler divide choice
  always_comb
  begin
    unique case (clock_control_register_q[ctp_pkg::SCALE_LSB +: 2])
      2'h0: pre_div = ctp_pkg::DIV_SC0;
      2'h1: pre_div = ctp_pkg::DIV_SC1;
      2'h2: pre_div = ctp_pkg::DIV_SC2;
      2'h3: pre_div = ctp_pkg::DIV_SC3;
    endcase
  end

  // Prescaler: one-cycle tick every pre_div clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_cnt_q <= ctp_pkg::RST_PRE;
    else if (pre_cnt_q >= pre_div - 6'h01)
      pre_cnt_q <= ctp_pkg::RST_PRE;
    else
      pre_cnt_q <= pre_cnt_q + 6'h01;
  end
  assign scale_tick = (pre_cnt_q >= pre_div - 6'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt0_sync_q  <= 3'h0;
      cnt1_sync_q  <= 3'h0;
      first_gate_bit_sync_q <= 2'h0;
      gate1_sync_q <= 2'h0;
    end
    else
    begin
      cnt0_sync_q  <= {cnt0_sync_q[1:0], first_count_pin};
      cnt1_sync_q  <= {cnt1_sync_q[1:0], second_count_pin};
      first_gate_bit_sync_q <= {first_gate_bit_sync_q[0], first_ext_gate_input};
      gate1_sync_q <= {gate1_sync_q[0], second_ext_gate_input};
    end
  end

  assign fall[0] = cnt0_sync_q[2] & ~cnt0_sync_q[1];
  assign fall[1] = cnt1_sync_q[2] & ~cnt1_sync_q[1];

  assign gate_act[0] = ~(first_gate_bit_sync_q[1]
                         ^ ext_interrupt_config_register_q[ctp_pkg::POL0_BIT]);
  assign gate_act[1] = ~(gate1_sync_q[1]
                         ^ ext_interrupt_config_register_q[ctp_pkg::POL1_BIT]);

  ctp_timer u_timer0
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .run_bit            (timer_control_register_q[ctp_pkg::RUN0_BIT]),
    .gate_bit           (timer_mode_register_q[ctp_pkg::GATE_BIT]),
    .gate_active        (gate_act[0]),
    .counter_select_bit (timer_mode_register_q[ctp_pkg::CSEL_BIT]),
    .sysclk_select_bit  (clock_control_register_q[ctp_pkg::SYS0_BIT]),
    .mode_select_bits   (timer_mode_register_q[ctp_pkg::MODE_LSB +: 2]),
    .scale_tick         (scale_tick),
    .pin_fall           (fall[0]),
    .wr_lo              (wr_lo[0]),
    .wr_hi              (wr_hi[0]),
    .wdata              (pwdata[7:0]),
    .low_byte           (lo_b[0]),
    .high_byte          (hi_b[0]),
    .overflow           (ovf_evt[0])
  );

  ctp_timer u_timer1
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .run_bit            (timer_control_register_q[ctp_pkg::RUN1_BIT]),
    .gate_bit           (timer_mode_register_q[ctp_pkg::GATE_BIT + ctp_pkg::MODE_T1_SHIFT]),
    .gate_active        (gate_act[1]),
    .counter_select_bit (timer_mode_register_q[ctp_pkg::CSEL_BIT + ctp_pkg::MODE_T1_SHIFT]),
    .sysclk_select_bit  (clock_control_register_q[ctp_pkg::SYS1_BIT]),
    .mode_select_bits   (timer_mode_register_q[ctp_pkg::MODE_T1_SHIFT +: 2]),
    .scale_tick         (scale_tick),
    .pin_fall           (fall[1]),
    .wr_lo              (wr_lo[1]),
    .wr_hi              (wr_hi[1]),
    .wdata              (pwdata[7:0]),
    .low_byte           (lo_b[1]),
    .high_byte          (hi_b[1]),
    .overflow           (ovf_evt[1])
  );

  // Outputs straight from flops
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
endmodule

// ---- verif/ctp_top_chk.sv ----
// Port checker for ctp_top: APB answer timing and read data shape.
// Assumes it is bound to ctp_top and sees only its ports.
`timescale 1ns/100ps
module ctp_top_chk
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // Decode of the mapped words
  assign mapped = (paddr <= ctp_pkg::OFF_IEN) && (paddr[1:0] == 2'h0);
  sequence wait_s;
    psel && penable && !pready;
  endsequence
  sequence done_s;
    psel && penable && pready;
  endsequence
  answer_next_a: assert property (wait_s |=> done_s)
    else $error("no answer after access");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_decode_a: assert property (done_s |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  err_alone_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  wr_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  stat_bits_a: assert property (done_s ##0 !pwrite && paddr == ctp_pkg::OFF_STAT
    |-> prdata[31:2] == 30'h0) else $error("status spare bits set");
endmodule

bind ctp_top ctp_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ---- verif/ctp_pins.sv ----
// Pin-side model: count pulses and gate levels for both timers.
// Assumes pclk from the bench; levels change right after rising edges.
`timescale 1ns/100ps
module ctp_pins
(
  // Clock
  input wire logic   pclk,
  // Pins toward the timers
  output logic [1:0] cnt_pins,
  output logic [1:0] gate_pins
);
  // Idle count pins high, gates low
  initial
  begin
    cnt_pins = 2'h3;
    gate_pins = 2'h0;
  end
  task automatic falls(input int t, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      cnt_pins[t] <= 1'b0;
      repeat (2) @(posedge pclk);
      cnt_pins[t] <= 1'b1;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic gate(input int t, input logic v);
    @(posedge pclk);
    gate_pins[t] <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for ctp_top: APB tasks and pin stimulus.
// Assumes ctp_pkg, ctp_top, ctp_pins and the checker compile first.
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, erv;
  logic [7:0]  paddr, lo, hi;
  logic [31:0] pwdata, prdata, rdv, cs, gb, rb, ob, pb;
  logic [1:0]  cnt_pins, gate_pins;
  int          num_errors, n_checks;

  ctp_top u_ctp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_count_pin(cnt_pins[0]), .second_count_pin(cnt_pins[1]),
    .first_ext_gate_input(gate_pins[0]), .second_ext_gate_input(gate_pins[1]), .irq(irq));
  ctp_pins u_ctp_pins (.pclk(pclk), .cnt_pins(cnt_pins), .gate_pins(gate_pins));

  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0);
    chk(rdv & m, e);
  endtask
  // Interrupt level after its lag
  task automatic ck_irq(input logic v);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 40; a += 4)
      rd(8'(a), 32'h0, 32'hFFFFFFFF);
    xfer(1'b0, 8'h2C, 32'h0);
    chk({31'h0, erv}, 32'h1);
    for (int t = 0; t < 2; t++)
    begin
      lo = ctp_pkg::OFF_T0LO + 8'(8 * t);
      hi = lo + 8'h04;
      cs = 32'h1 << (ctp_pkg::CSEL_BIT + 4 * t);
      gb = 32'h1 << (ctp_pkg::GATE_BIT + 4 * t);
      rb = 32'h1 << (ctp_pkg::RUN0_BIT + 2 * t);
      ob = 32'h1 << (ctp_pkg::OVF0_BIT + 2 * t);
      pb = 32'h1 << (ctp_pkg::POL0_BIT + 4 * t);
      wr(lo, 32'hE3);
      wr(hi, 32'h12);
      wr(ctp_pkg::OFF_MODE, cs);
      wr(ctp_pkg::OFF_CTRL, rb);
      // low byte masked to bits 4..0
      rd(lo, 32'h03, 32'h1F);
      rd(hi, 32'h12, 32'hFF);
      u_ctp_pins.falls(t, 3);
      rd(lo, 32'h06, 32'h1F);
      wr(ctp_pkg::OFF_MODE, cs | gb);
      wr(ctp_pkg::OFF_EXTC, pb);
      u_ctp_pins.falls(t, 2);
      rd(lo, 32'h06, 32'h1F);
      u_ctp_pins.gate(t, 1'b1);
      u_ctp_pins.falls(t, 2);
      rd(lo, 32'h08, 32'h1F);
      wr(ctp_pkg::OFF_EXTC, 32'h0);
      u_ctp_pins.falls(t, 1);
      rd(lo, 32'h08, 32'h1F);
      u_ctp_pins.gate(t, 1'b0);
      u_ctp_pins.falls(t, 1);
      rd(lo, 32'h09, 32'h1F);
      wr(ctp_pkg::OFF_MODE, cs | (32'h1 << (4 * t)));
      u_ctp_pins.falls(t, 1);
      rd(lo, 32'h09, 32'h1F);
      wr(ctp_pkg::OFF_MODE, cs);
      wr(lo, 32'h1F);
      wr(hi, 32'hFF);
      wr(ctp_pkg::OFF_IEN, 32'h1 << t);
      u_ctp_pins.falls(t, 1);
      rd(lo, 32'h00, 32'h1F);
      rd(hi, 32'h00, 32'hFF);
      rd(ctp_pkg::OFF_STAT, 32'h1 << t, 32'hFFFFFFFF);
      rd(ctp_pkg::OFF_CTRL, rb | ob, 32'hFF);
      ck_irq(1'b1);
      wr(ctp_pkg::OFF_IEN, 32'h0);
      ck_irq(1'b0);
      wr(ctp_pkg::OFF_IEN, 32'h1 << t);
      wr(ctp_pkg::OFF_CLR, 32'h1 << t);
      ck_irq(1'b0);
      rd(ctp_pkg::OFF_STAT, 32'h0, 32'hFFFFFFFF);
      wr(ctp_pkg::OFF_CTRL, 32'h0);
    end
    wr(ctp_pkg::OFF_STAT, 32'h3);
    rd(ctp_pkg::OFF_STAT, 32'h0, 32'hFFFFFFFF);
    for (int s = 0; s < 3; s++)
    begin
      wr(ctp_pkg::OFF_T0LO, 32'h0);
      wr(ctp_pkg::OFF_MODE, 32'h0);
      wr(ctp_pkg::OFF_CLK, (s == 0) ? 32'h8 : ((s == 1) ? 32'h1 : 32'h2));
      wr(ctp_pkg::OFF_CTRL, 32'h10);
      wr(ctp_pkg::OFF_CTRL, 32'h0);
      xfer(1'b0, ctp_pkg::OFF_T0LO, 32'h0);
      // Run stands for four edges: sysclk steps four times, /4 once, /48 at most once
      if (s < 2)
        chk({27'h0, rdv[4:0]}, (s == 0) ? 32'h4 : 32'h1);
      else
        chk({31'h0, rdv[4:0] < 5'h02}, 32'h1);
    end
    stop_test();
  end
endmodule
